//--- logic/arsf_chan_flags.sv
// arsf_chan_flags: done and overrun flags of one converter channel
// assumes: event, clear and read strobes are single-cycle and on mclk
`timescale 1ns/100ps
`default_nettype none
module arsf_chan_flags (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// events
	input wire logic eoc_hit,
	input wire logic enabled,
	input wire logic result_read,
	input wire logic status_read,
	// flags
	output logic done_flag,
	output logic channel_overrun_flag
);
	logic set_done;
	assign set_done = eoc_hit && enabled;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			done_flag <= 1'b0;
		end else if (set_done) begin
			done_flag <= 1'b1;
		end else if (result_read) begin
			done_flag <= 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			channel_overrun_flag <= 1'b0;
		end else if (set_done && done_flag) begin
			channel_overrun_flag <= 1'b1;
		end else if (status_read) begin
			channel_overrun_flag <= 1'b0;
		end
	end
endmodule : arsf_chan_flags
`default_nettype wire

//--- logic/arsf_pkg.sv
// arsf_pkg: shared constants and carriers for the converter result/flag block
// assumes: one clock domain, no register bus; reads arrive as one-cycle strobes
package arsf_pkg;
	localparam int unsigned NUM_CHANNELS = 8;
	localparam int unsigned RESULT_WIDTH = 10;
	localparam int unsigned CHAN_IDX_WIDTH = 3;
	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 10'h000;
	localparam logic [CHAN_IDX_WIDTH-1:0] CHAN_RESET = 3'h0;
	localparam int unsigned SYNC_STAGES = 3;

	// end-of-conversion event from the analog core
	typedef struct packed {
		logic valid;
		logic [CHAN_IDX_WIDTH-1:0] chan;
		logic [RESULT_WIDTH-1:0] data;
	} arsf_eoc_s;

	// software read strobes
	typedef struct packed {
		logic status;
		logic last;
		logic chan_valid;
		logic [CHAN_IDX_WIDTH-1:0] chan;
	} arsf_read_s;

	// global status flags
	typedef struct packed {
		logic data_ready_flag;
		logic general_overrun_flag;
		logic sleeping;
	} arsf_status_s;
endpackage : arsf_pkg

//--- logic/arsf_top.sv
// arsf_top: result storage and status flags of a converter controller
// assumes: conversion core gives one-cycle tagged end pulses; software reads via strobes
`timescale 1ns/100ps
`default_nettype none
module arsf_top #(
	parameter int unsigned NUM_CH = arsf_pkg::NUM_CHANNELS,
	parameter int unsigned RES_W = arsf_pkg::RESULT_WIDTH,
	parameter int unsigned IDX_W = arsf_pkg::CHAN_IDX_WIDTH
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// conversion core
	input wire arsf_pkg::arsf_eoc_s eoc,
	// software control
	input wire logic [NUM_CH-1:0] chan_enable,
	input wire logic sleep_select,
	input wire arsf_pkg::arsf_read_s rd,
	// results
	output logic [NUM_CH*RES_W-1:0] channel_result_reg,
	output logic [RES_W-1:0] last_result_reg,
	output logic [IDX_W-1:0] last_result_chan,
	// flags
	output logic [NUM_CH-1:0] done_flags,
	output logic [NUM_CH-1:0] channel_overrun_flag,
	output arsf_pkg::arsf_status_s status
);
	initial begin
		if (NUM_CH != arsf_pkg::NUM_CHANNELS || RES_W != arsf_pkg::RESULT_WIDTH
				|| IDX_W != arsf_pkg::CHAN_IDX_WIDTH) begin
			$error("arsf_top: parameters must match package widths");
		end
	end

	// sleep select comes from a pin domain: three-stage sync
	logic [arsf_pkg::SYNC_STAGES-1:0] sleep_sync;
	logic sleep_req;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sleep_sync <= '0;
			sleep_req <= 1'b0;
		end else begin
			sleep_sync <= {sleep_sync[arsf_pkg::SYNC_STAGES-2:0], sleep_select};
			if (sleep_sync[1] == sleep_sync[2]) begin
				sleep_req <= sleep_sync[2];
			end
		end
	end

	// one-hot decode shared by event and read paths
	function automatic logic [NUM_CH-1:0] onehot(input logic [IDX_W-1:0] idx);
		logic [NUM_CH-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction : onehot

	logic [NUM_CH-1:0] eoc_hit;
	logic [NUM_CH-1:0] rd_hit;
	logic last_is_read;
	assign eoc_hit = eoc.valid ? onehot(eoc.chan) : '0;
	// last read maps to its stored channel
	assign last_is_read = rd.last;
	assign rd_hit = (rd.chan_valid ? onehot(rd.chan) : '0)
		| (last_is_read ? onehot(last_result_chan) : '0);

	logic store;
	// store even if another channel disables
	assign store = eoc.valid && chan_enable[eoc.chan];

	logic done_of_eoc;
	assign done_of_eoc = |(done_flags & eoc_hit);

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : g_ch
			// per-channel result store
			// own register per slice: one process may own a variable
			logic [RES_W-1:0] res_q;
			always_ff @(posedge mclk or posedge rst) begin
				if (rst) begin
					res_q <= arsf_pkg::RESULT_RESET;
				end else if (store && eoc_hit[g]) begin
					res_q <= eoc.data;
				end
			end
			assign channel_result_reg[g*RES_W +: RES_W] = res_q;

			arsf_chan_flags u_flags (
				.mclk(mclk),
				.rst(rst),
				.eoc_hit(eoc_hit[g]),
				.enabled(chan_enable[g]),
				.result_read(rd_hit[g]),
				.status_read(rd.status),
				.done_flag(done_flags[g]),
				.channel_overrun_flag(channel_overrun_flag[g])
			);
		end
	endgenerate

	// last result and its channel tag
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			last_result_reg <= arsf_pkg::RESULT_RESET;
			last_result_chan <= arsf_pkg::CHAN_RESET;
		end else if (store) begin
			last_result_reg <= eoc.data;
			last_result_chan <= eoc.chan;
		end
	end

	// one flop per status field, each owned by its own process
	logic data_ready_q;
	logic general_overrun_q;
	logic sleeping_q;
	assign status.data_ready_flag = data_ready_q;
	assign status.general_overrun_flag = general_overrun_q;
	assign status.sleeping = sleeping_q;

	// data ready set wins, last read clears
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			data_ready_q <= 1'b0;
		end else if (store) begin
			data_ready_q <= 1'b1;
		end else if (last_is_read) begin
			data_ready_q <= 1'b0;
		end
	end

	// general overrun, set wins over status read
	logic gov_set;
	assign gov_set = store && (data_ready_q || done_of_eoc);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			general_overrun_q <= 1'b0;
		end else if (gov_set) begin
			general_overrun_q <= 1'b1;
		end else if (rd.status) begin
			general_overrun_q <= 1'b0;
		end
	end

	// sleep only at a conversion end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			sleeping_q <= 1'b0;
		end else if (!sleep_req) begin
			sleeping_q <= 1'b0;
		end else if (eoc.valid) begin
			sleeping_q <= 1'b1;
		end
	end
endmodule : arsf_top
`default_nettype wire

//--- sim/arsf_chk.sv
// arsf_chk: pulse, read and flag relations
// assumes: bound into arsf_top, one clock
`timescale 1ns/100ps
`default_nettype none
module arsf_chk #(parameter int unsigned NUM_CH = 8) (
	// clock
	input wire logic mclk,
	input wire logic rst,
	// inputs
	input wire arsf_pkg::arsf_eoc_s eoc,
	input wire logic [NUM_CH-1:0] chan_enable,
	input wire arsf_pkg::arsf_read_s rd,
	// flags
	input wire logic [NUM_CH-1:0] done_flags,
	input wire logic [NUM_CH-1:0] channel_overrun_flag,
	input wire arsf_pkg::arsf_status_s status
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	logic hit;
	assign hit = eoc.valid && chan_enable[eoc.chan];
	AST_READY_SET: assert property (hit |=> status.data_ready_flag)
		else $error("data ready lost");
	AST_GOV: assert property (hit && status.data_ready_flag |=> status.general_overrun_flag)
		else $error("gov lost");
	AST_GOV_CLR: assert property (rd.status && !hit |=> !status.general_overrun_flag)
		else $error("gov kept");
	AST_OVR: assert property (hit && done_flags[eoc.chan] |=> channel_overrun_flag[$past(eoc.chan)])
		else $error("ovr lost");
	AST_OVR_CLR: assert property (rd.status && !(hit && done_flags[eoc.chan]) |=> channel_overrun_flag == '0)
		else $error("ovr kept");
	AST_DONE: assert property (!hit |=> (done_flags & ~$past(done_flags)) == '0)
		else $error("done rose");
	AST_HOLD: assert property (!hit && !rd.last |=> $stable(status.data_ready_flag))
		else $error("data ready moved");
	AST_SLEEP: assert property ($rose(status.sleeping) |-> $past(eoc.valid))
		else $error("early sleep");
endmodule : arsf_chk
bind arsf_top arsf_chk #(.NUM_CH(NUM_CH)) u_chk (.mclk(mclk), .rst(rst), .eoc(eoc), .chan_enable(chan_enable),
	.rd(rd), .done_flags(done_flags), .channel_overrun_flag(channel_overrun_flag), .status(status));
`default_nettype wire

//--- sim/arsf_core_model.sv
// arsf_core_model: conversion core, one end pulse per request
// assumes: fire sampled on mclk
`timescale 1ns/100ps
`default_nettype none
module arsf_core_model (
	// clock
	input wire logic mclk,
	input wire logic rst,
	// request
	input wire logic fire,
	input wire logic [2:0] fch,
	input wire logic [9:0] fdata,
	// end pulse
	output arsf_pkg::arsf_eoc_s eoc
);
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			eoc <= '0;
		end else begin
			eoc.valid <= fire;
			eoc.chan <= fch;
			// idle data toggles, never valid-looking
			eoc.data <= fire ? fdata : ~eoc.data;
		end
	end
endmodule : arsf_core_model
`default_nettype wire

//--- sim/test_adc_result_status_flags.sv
// test_adc_result_status_flags: random ends and reads vs reference
// assumes: core model and bound checker
`timescale 1ns/100ps
`default_nettype none
module test_adc_result_status_flags;
	typedef struct packed {
		logic [79:0] res;
		logic [9:0] last;
		logic [2:0] lch;
		logic [7:0] done;
		logic [7:0] ovr;
		logic rdy;
		logic gov;
	} arsf_exp_s;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic fire = 1'b0;
	logic [2:0] fch = 3'h0;
	logic [9:0] fdata = 10'h000;
	logic [7:0] chan_enable = 8'hFF;
	logic sleep_select = 1'b0;
	arsf_pkg::arsf_read_s rd = '0;
	arsf_pkg::arsf_eoc_s eoc;
	arsf_pkg::arsf_status_s status;
	arsf_exp_s want = '0;
	logic [110:0] got;
	int fail_count = 0;
	int n_compared = 0;
	always #5 mclk = ~mclk;
	arsf_core_model CORE (.mclk(mclk), .rst(rst), .fire(fire), .fch(fch), .fdata(fdata), .eoc(eoc));
	arsf_top DUT (.mclk(mclk), .rst(rst), .eoc(eoc), .chan_enable(chan_enable), .sleep_select(sleep_select),
		.rd(rd), .channel_result_reg(got[110:31]), .last_result_reg(got[30:21]), .last_result_chan(got[20:18]),
		.done_flags(got[17:10]), .channel_overrun_flag(got[9:2]), .status(status));
	assign got[1:0] = status[2:1];
	// clears first, then sets, so a coinciding set wins
	function automatic arsf_exp_s predict(arsf_exp_s s, arsf_pkg::arsf_eoc_s e, logic [7:0] en,
		arsf_pkg::arsf_read_s r);
		arsf_exp_s n;
		n = s;
		if (r.chan_valid) n.done[r.chan] = 1'b0;
		if (r.last) n.done[s.lch] = 1'b0;
		if (r.last) n.rdy = 1'b0;
		if (r.status) n.ovr = '0;
		if (r.status) n.gov = 1'b0;
		if (e.valid && en[e.chan]) begin
			n.res[e.chan*10 +: 10] = e.data;
			n.last = e.data;
			n.lch = e.chan;
			n.done[e.chan] = 1'b1;
			n.rdy = 1'b1;
			n.ovr[e.chan] = n.ovr[e.chan] | s.done[e.chan];
			n.gov = n.gov | s.done[e.chan] | s.rdy;
		end
		return n;
	endfunction : predict
	always @(posedge mclk) want = rst ? '0 : predict(want, eoc, chan_enable, rd);
	always @(negedge mclk) begin
		if (!rst) begin
			n_compared++;
			if (got !== want) begin
				fail_count++;
				$display("FAIL %0t got %h want %h", $time, got, want);
			end
		end
	end
	task drive(input logic f, input logic [2:0] c, input logic [5:0] r, input logic [7:0] en);
		@(posedge mclk);
		#1;
		fire = f;
		fch = c;
		fdata = 10'($urandom);
		rd = r;
		chan_enable = en;
		// sleep level may toggle in the same step as this fire
		sleep_select = ($urandom_range(15) == 0) ? ~sleep_select : sleep_select;
	endtask : drive
	task give_verdict;
		if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	initial begin
		void'($urandom(32'hB3B9BF5C));
		repeat (6) @(posedge mclk);
		#1;
		rst = 1'b0;
		// second end on ch2 meets a status read
		drive(1'b1, 3'h2, 6'h00, 8'hFF);
		drive(1'b1, 3'h2, 6'h00, 8'hFF);
		drive(1'b0, 3'h2, 6'h20, 8'hFF);
		drive(1'b0, 3'h0, 6'h10, 8'hFB);
		// reference checks flags, not software use of them
		repeat (3000) drive(1'($urandom), 3'($urandom), 6'($urandom & $urandom),
			($urandom_range(7) == 0) ? 8'($urandom) : chan_enable);
		@(posedge mclk);
		give_verdict;
	end
	initial begin
		#50000;
		fail_count++;
		give_verdict;
	end
endmodule : test_adc_result_status_flags
`default_nettype wire
